// *** alc_defs.svh ***
// Offsets, field positions, reset values and constants of the gain loop control registers.
`ifndef ALC_DEFS_SVH
`define ALC_DEFS_SVH
`define ALC_ADDR_W      5
`define ALC_OFS_CTRL    5'h14
`define ALC_OFS_CNT_LO  5'h15
`define ALC_OFS_CNT_HI  5'h16
`define ALC_OFS_IC_A    5'h17
`define ALC_OFS_IC_B    5'h18
`define ALC_OFS_RB_A    5'h19
`define ALC_OFS_RB_B    5'h1A
`define ALC_BIT_EXP     0
`define ALC_BIT_CONT    1
`define ALC_BIT_RELOAD  2
`define ALC_BIT_FREEZE  3
`define ALC_BIT_SHIFT   4
`define ALC_CTRL_W      6
`define ALC_CTRL_RESET  6'h02
`define ALC_CNT_RESET   16'h0000
`define ALC_IC_RESET    8'h00
`define ALC_EXP_FORCED  3'h7
`endif

// *** alc_pkg.sv ***
// Types shared by the gain loop control registers.
package alc_pkg;
   typedef struct packed {
      logic [1:0] loop_shift;
      logic       freeze;
      logic       reload;
      logic       cont_run;
      logic       exp_ovr;
   } alc_ctrl_t;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [4:0] addr;
      logic [7:0] wdata;
   } alc_host_t;

   typedef enum logic [1:0] {
      ALC_IDLE,
      ALC_GATED,
      ALC_CONT
   } alc_state_t;
endpackage

// *** alc_loop_ctrl.sv ***
// Control and initial-condition registers of the dual-channel gain loop.
`timescale 1ns/1ps
`include "alc_defs.svh"

module alc_loop_ctrl
   import alc_pkg::*;
(
   // Clock, reset and enable.
   input  wire logic        i_clk_sys,
   input  wire logic        i_arst_n,
   input  wire logic        i_ce,
   // Host register port.
   input  wire alc_host_t   i_host,
   output logic [7:0]       o_rdata,
   output logic             o_rvalid,
   // Gain loop inputs.
   input  wire logic        i_agc_gate_pin,
   input  wire logic [2:0]  i_exp_a,
   input  wire logic [2:0]  i_exp_b,
   input  wire logic [7:0]  i_integ_msb_a,
   input  wire logic [7:0]  i_integ_msb_b,
   // Gain loop controls.
   output logic [2:0]       o_exp_a,
   output logic [2:0]       o_exp_b,
   output logic             o_loop_active,
   output logic             o_integ_load,
   output logic             o_integ_hold,
   output logic [1:0]       o_loop_shift,
   output logic [7:0]       o_start_level_a,
   output logic [7:0]       o_start_level_b
);

   // =====================================================================
   // Address decode.
   // =====================================================================
   // Tells whether an access targets a given offset.
   function automatic logic hit(input logic [4:0] addr, input logic [4:0] ofs);
      hit = (addr == ofs);
   endfunction

   // =====================================================================
   // Register file.
   // =====================================================================
   alc_ctrl_t   ctrl;
   alc_ctrl_t   next_ctrl;
   logic [15:0] active_cycles;
   logic [15:0] next_active_cycles;
   logic [7:0]  start_a;
   logic [7:0]  next_start_a;
   logic [7:0]  start_b;
   logic [7:0]  next_start_b;
   logic [7:0]  next_rdata;
   logic        next_rvalid;

   always_comb begin
      next_ctrl          = ctrl;
      next_active_cycles = active_cycles;
      next_start_a       = start_a;
      next_start_b       = start_b;
      next_rdata         = o_rdata;
      next_rvalid        = 1'b0;
      if (i_host.wr) begin
         if (hit(i_host.addr, `ALC_OFS_CTRL)) begin
            next_ctrl = i_host.wdata[`ALC_CTRL_W-1:0];
         end
         if (hit(i_host.addr, `ALC_OFS_CNT_LO)) begin
            next_active_cycles[7:0] = i_host.wdata;
         end
         if (hit(i_host.addr, `ALC_OFS_CNT_HI)) begin
            next_active_cycles[15:8] = i_host.wdata;
         end
         if (hit(i_host.addr, `ALC_OFS_IC_A)) begin
            next_start_a = i_host.wdata;
         end
         if (hit(i_host.addr, `ALC_OFS_IC_B)) begin
            next_start_b = i_host.wdata;
         end
      end
      if (i_host.rd) begin
         next_rvalid = 1'b1;
         next_rdata  = 8'h00;
         if (hit(i_host.addr, `ALC_OFS_CTRL)) begin
            next_rdata = {2'h0, ctrl};
         end
         if (hit(i_host.addr, `ALC_OFS_CNT_LO)) begin
            next_rdata = active_cycles[7:0];
         end
         if (hit(i_host.addr, `ALC_OFS_CNT_HI)) begin
            next_rdata = active_cycles[15:8];
         end
         if (hit(i_host.addr, `ALC_OFS_IC_A)) begin
            next_rdata = start_a;
         end
         if (hit(i_host.addr, `ALC_OFS_IC_B)) begin
            next_rdata = start_b;
         end
         if (hit(i_host.addr, `ALC_OFS_RB_A)) begin
            next_rdata = i_integ_msb_a;
         end
         if (hit(i_host.addr, `ALC_OFS_RB_B)) begin
            next_rdata = i_integ_msb_b;
         end
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         ctrl          <= `ALC_CTRL_RESET;
         active_cycles <= `ALC_CNT_RESET;
         start_a       <= `ALC_IC_RESET;
         start_b       <= `ALC_IC_RESET;
         o_rdata       <= 8'h00;
         o_rvalid      <= 1'b0;
      end else if (i_ce) begin
         ctrl          <= next_ctrl;
         active_cycles <= next_active_cycles;
         start_a       <= next_start_a;
         start_b       <= next_start_b;
         o_rdata       <= next_rdata;
         o_rvalid      <= next_rvalid;
      end
   end

   // =====================================================================
   // Loop activity sequencer.
   // =====================================================================
   alc_state_t  state;
   alc_state_t  next_state;
   logic [15:0] remain;
   logic [15:0] next_remain;
   logic        gate_q;
   logic        gate_rise;
   logic        next_active;

   assign gate_rise = i_agc_gate_pin & ~gate_q;

   always_comb begin
      next_state  = state;
      next_remain = remain;
      unique case (state)
         ALC_IDLE: begin
            if (ctrl.cont_run) begin
               next_state = ALC_CONT;
            end else if (gate_rise && (active_cycles != 16'h0000)) begin
               next_state  = ALC_GATED;
               next_remain = active_cycles;
            end
         end
         ALC_GATED: begin
            if (ctrl.cont_run) begin
               next_state  = ALC_CONT;
               next_remain = 16'h0000;
            end else if (remain == 16'h0001) begin
               next_state  = ALC_IDLE;
               next_remain = 16'h0000;
            end else begin
               next_remain = remain - 16'h0001;
            end
         end
         ALC_CONT: begin
            if (!ctrl.cont_run) begin
               next_state = ALC_IDLE;
            end
         end
      endcase
   end

   assign next_active = (next_state != ALC_IDLE);

   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         state  <= ALC_IDLE;
         remain <= 16'h0000;
         gate_q <= 1'b0;
      end else if (i_ce) begin
         state  <= next_state;
         remain <= next_remain;
         gate_q <= i_agc_gate_pin;
      end
   end

   // =====================================================================
   // Loop control outputs.
   // =====================================================================
   logic [2:0] next_exp_a;
   logic [2:0] next_exp_b;
   logic       next_load;

   always_comb begin
      next_exp_a = ctrl.exp_ovr ? `ALC_EXP_FORCED : i_exp_a;
      next_exp_b = ctrl.exp_ovr ? `ALC_EXP_FORCED : i_exp_b;
      next_load  = ctrl.reload & next_active & ~o_loop_active;
   end

   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_exp_a         <= 3'h0;
         o_exp_b         <= 3'h0;
         o_loop_active   <= 1'b0;
         o_integ_load    <= 1'b0;
         o_integ_hold    <= 1'b0;
         o_loop_shift    <= 2'h0;
         o_start_level_a <= `ALC_IC_RESET;
         o_start_level_b <= `ALC_IC_RESET;
      end else if (i_ce) begin
         o_exp_a         <= next_exp_a;
         o_exp_b         <= next_exp_b;
         o_loop_active   <= next_active;
         o_integ_load    <= next_load;
         o_integ_hold    <= ctrl.freeze;
         o_loop_shift    <= ctrl.loop_shift;
         o_start_level_a <= start_a;
         o_start_level_b <= start_b;
      end
   end

   // =====================================================================
   // Assertions.
   // =====================================================================
   default clocking alc_cb @(posedge i_clk_sys);
   endclocking
   default disable iff (!i_arst_n);

   exp_forced_a: assert property (
      i_ce && ctrl.exp_ovr |=> o_exp_a == 3'h7 && o_exp_b == 3'h7)
      else $error("Exponent not forced to seven.");

   exp_pass_a: assert property (
      i_ce && !ctrl.exp_ovr |=> o_exp_a == $past(i_exp_a) && o_exp_b == $past(i_exp_b))
      else $error("Exponent not passed through.");

   cont_run_a: assert property (
      i_ce && ctrl.cont_run |=> o_loop_active)
      else $error("Loop not active in continuous run.");

   gated_idle_a: assert property (
      i_ce && !ctrl.cont_run && state == ALC_IDLE && !gate_rise |=> !o_loop_active)
      else $error("Loop active without a gate.");

   reload_off_a: assert property (
      i_ce && !ctrl.reload |=> !o_integ_load)
      else $error("Integrator reloaded while reload disabled.");

   reload_edge_a: assert property (
      i_ce && ctrl.reload && !o_loop_active && next_active |=> o_integ_load)
      else $error("Integrator not reloaded on activation.");

   hold_shift_a: assert property (
      i_ce |=> o_integ_hold == $past(ctrl.freeze) && o_loop_shift == $past(ctrl.loop_shift))
      else $error("Hold or shift output lags its field.");

   count_bytes_a: assert property (
      i_ce && i_host.wr && i_host.addr == 5'h16
      |=> active_cycles[15:8] == $past(i_host.wdata))
      else $error("Count high byte not stored.");

   count_low_a: assert property (
      i_ce && i_host.wr && i_host.addr == `ALC_OFS_CNT_LO
      |=> active_cycles[7:0] == $past(i_host.wdata))
      else $error("Count low byte not stored.");

   level_read_a: assert property (
      i_ce && i_host.rd && i_host.addr == `ALC_OFS_RB_A
      |=> o_rvalid && o_rdata == $past(i_integ_msb_a))
      else $error("Channel A readback does not show integrator level.");

   gate_count_a: assert property (
      i_ce && state == ALC_GATED && !ctrl.cont_run && remain != 16'h0001
      |=> state == ALC_GATED && remain == $past(remain) - 16'h0001)
      else $error("Gated window did not count down.");

   start_level_a: assert property (
      i_ce && i_host.wr && i_host.addr == 5'h17 ##1 i_ce
      |=> o_start_level_a == $past(i_host.wdata, 2))
      else $error("Channel A start level not delivered.");

   readback_a: assert property (
      i_ce && i_host.rd && i_host.addr == 5'h1A
      |=> o_rvalid && o_rdata == $past(i_integ_msb_b))
      else $error("Readback does not show integrator level.");

   gate_load_a: assert property (
      i_ce && state == ALC_IDLE && !ctrl.cont_run && gate_rise && active_cycles != 16'h0000
      |=> o_loop_active && remain == $past(active_cycles))
      else $error("Gate did not load the active count.");

   gate_end_a: assert property (
      i_ce && state == ALC_GATED && !ctrl.cont_run && remain == 16'h0001
      |=> !o_loop_active && state == ALC_IDLE)
      else $error("Gated window did not close on time.");

   gated_run_c: cover property (state == ALC_GATED ##1 state == ALC_IDLE);
   cont_run_c: cover property (state == ALC_CONT ##1 state == ALC_IDLE);
   reload_c: cover property (o_integ_load && o_loop_active);
   readback_c: cover property (o_rvalid && o_rdata != 8'h00);

endmodule

// *** alc_vga_model.sv ***
// Behavioural model of the gain integrator and exponent path beside the register block.
`timescale 1ns/1ps

module alc_vga_model (
   // Clock and reset.
   input  wire logic       i_clk_sys,
   input  wire logic       i_arst_n,
   // Loop controls from the register block.
   input  wire logic       i_loop_active,
   input  wire logic       i_integ_load,
   input  wire logic       i_integ_hold,
   input  wire logic [7:0] i_start_level_a,
   input  wire logic [7:0] i_start_level_b,
   // Exponents and integrator magnitudes back to the block.
   output logic [2:0]      o_exp_a,
   output logic [2:0]      o_exp_b,
   output logic [7:0]      o_integ_msb_a,
   output logic [7:0]      o_integ_msb_b
);
   // ==========================================================================
   // Exponents change every cycle so a stale value never matches.
   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_exp_a <= 3'h0;
         o_exp_b <= 3'h5;
      end else begin
         o_exp_a <= o_exp_a + 3'h3;
         o_exp_b <= o_exp_b - 3'h1;
      end
   end
   // ==========================================================================
   // Integrators take the start levels on reload or hold, else climb while active.
   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_integ_msb_a <= 8'h00;
         o_integ_msb_b <= 8'h00;
      end else if (i_integ_load || i_integ_hold) begin
         o_integ_msb_a <= i_start_level_a;
         o_integ_msb_b <= i_start_level_b;
      end else if (i_loop_active) begin
         o_integ_msb_a <= o_integ_msb_a + 8'h01;
         o_integ_msb_b <= o_integ_msb_b + 8'h03;
      end
   end
endmodule

// *** tb_top.sv ***
// Self-checking testbench of the gain loop control registers.
`timescale 1ns/1ps

module tb_top
   import alc_pkg::*;
;
   logic       i_clk_sys = 1'b0;
   logic       i_arst_n  = 1'b0;
   logic       ce        = 1'b1;
   logic       gate      = 1'b0;
   alc_host_t  host      = '0;
   logic [7:0] rdata, lvl_a, lvl_b, msb_a, msb_b;
   logic [2:0] exp_a, exp_b, oexp_a, oexp_b, prev_a, prev_b;
   logic       rvalid, active, load, hold;
   logic [1:0] shift;
   integer     seed = 32'h9AE66BCE;
   integer     miscompares = 0;
   integer     total_checks = 0;
   integer     cycles = 0;
   integer     mdl [20:24];
   integer     k, n_act, n_load;

   alc_loop_ctrl alc_loop_ctrl_inst (.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .i_ce(ce),
      .i_host(host), .o_rdata(rdata), .o_rvalid(rvalid), .i_agc_gate_pin(gate),
      .i_exp_a(exp_a), .i_exp_b(exp_b), .i_integ_msb_a(msb_a), .i_integ_msb_b(msb_b),
      .o_exp_a(oexp_a), .o_exp_b(oexp_b), .o_loop_active(active), .o_integ_load(load),
      .o_integ_hold(hold), .o_loop_shift(shift), .o_start_level_a(lvl_a),
      .o_start_level_b(lvl_b));
   alc_vga_model alc_vga_model_inst (.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n),
      .i_loop_active(active), .i_integ_load(load), .i_integ_hold(hold),
      .i_start_level_a(lvl_a), .i_start_level_b(lvl_b), .o_exp_a(exp_a), .o_exp_b(exp_b),
      .o_integ_msb_a(msb_a), .o_integ_msb_b(msb_b));

   // ==========================================================================
   // Clock, exponent history and hang guard.
   always #2 i_clk_sys = ~i_clk_sys;
   always @(posedge i_clk_sys) begin
      prev_a <= exp_a;
      prev_b <= exp_b;
      cycles = cycles + 1;
      if (cycles == 20000) begin
         miscompares = miscompares + 1;
         complete_run();
      end
   end

   // ==========================================================================
   // Shared tasks.
   task automatic complete_run();
      if (miscompares == 0 && total_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic check(input logic [15:0] seen, input logic [15:0] want);
      total_checks = total_checks + 1;
      if (seen !== want) begin
         miscompares = miscompares + 1;
         $display("BAD %0t seen %h expected %h", $time, seen, want);
      end
   endtask
   task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
      @(posedge i_clk_sys);
      host <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      if (ce && a >= 5'h14 && a <= 5'h18) mdl[a] = d;
      @(posedge i_clk_sys);
      host.wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [4:0] a, input logic [7:0] want);
      @(posedge i_clk_sys);
      host <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge i_clk_sys);
      host.rd <= 1'b0;
      #1;
      check(16'(rvalid), 16'h0001);
      check(16'(rdata), 16'(want));
   endtask
   task automatic gate_run(input integer cnt, input logic rl);
      wr_reg(5'h15, 8'(cnt));
      wr_reg(5'h16, 8'(cnt >> 8));
      wr_reg(5'h14, {5'h00, rl, 2'h0});
      repeat (3) @(posedge i_clk_sys);
      gate <= 1'b1;
      n_act = 0;
      n_load = 0;
      repeat (cnt + 6) begin
         @(posedge i_clk_sys);
         #1;
         n_act = n_act + 32'(active);
         n_load = n_load + 32'(load);
      end
      @(posedge i_clk_sys);
      gate <= 1'b0;
      check(16'(n_act), 16'(cnt));
      check(16'(n_load), 16'(rl && cnt != 0));
   endtask

   // ==========================================================================
   // Main sequence.
   initial begin
      mdl[20] = 2;
      for (k = 21; k <= 24; k++) mdl[k] = 0;
      repeat (2) @(posedge i_clk_sys);
      i_arst_n <= 1'b1;
      for (k = 20; k <= 24; k++) rd_reg(5'(k), 8'(mdl[k]));
      for (k = 0; k < 30; k++) wr_reg(5'(20 + {$random(seed)} % 5), 8'($random(seed)));
      for (k = 20; k <= 24; k++) rd_reg(5'(k), 8'(k == 20 ? mdl[k] & 8'h3F : mdl[k]));
      rd_reg(5'h03, 8'h00);
      @(posedge i_clk_sys);
      ce <= 1'b0;
      wr_reg(5'h17, 8'(~mdl[23]));
      ce <= 1'b1;
      rd_reg(5'h17, 8'(mdl[23]));
      for (k = 0; k < 8; k++) begin
         wr_reg(5'h14, 8'(((k % 4) << 4) | ((k / 4) << 3) | 2 | (k / 4)));
         gate <= (k % 2 == 0);
         @(posedge i_clk_sys);
         @(posedge i_clk_sys);
         #1;
         check(16'(shift), 16'(k % 4));
         check(16'(hold), 16'(k / 4));
         check(16'(oexp_a), 16'(k >= 4 ? 7 : prev_a));
         check(16'(oexp_b), 16'(k >= 4 ? 7 : prev_b));
         check(16'(active), 16'h0001);
         check(16'({lvl_b, lvl_a}), 16'((mdl[24] << 8) | mdl[23]));
      end
      wr_reg(5'h19, 8'(~mdl[23]));
      rd_reg(5'h19, 8'(mdl[23]));
      rd_reg(5'h1A, 8'(mdl[24]));
      gate_run(0, 1'b1);
      gate_run(3, 1'b1);
      gate_run(1 + {$random(seed)} % 20, 1'b0);
      gate_run(257 + {$random(seed)} % 16, 1'b1);
      complete_run();
   end
endmodule
